// [core/fpt_top.sv]
// Fan power and tach controller top: AXI4-Lite registers, four PWM channels,
// rotating tach measurement, fail-safe and staggered start-up.
// Assumes tach pins are asynchronous and fan switches are open-drain.
//
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
module fpt_top
  import fpt_pkg::*;
#(
  parameter int unsigned MEAS_CYCLES = MEAS_CYC,  // Window length, cycles
  parameter int unsigned SPIN_CYCLES = SPIN_CYC,  // Start-up gap, cycles
  parameter int unsigned MS_CYCLES   = CLK_HZ / 1000  // Fail-safe ms tick
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Fans
  input  wire logic [3:0]  tach_in,
  output logic [3:0]       fan_sw_oe,
  output logic [3:0]       fan_sw_o,
  output logic             irq
);
  logic [7:0]  pwr_q [NFAN];  // Power settings
  logic [3:0]  report_q;      // Report enables
  logic [3:0]  fsen_q;        // Fail-safe enables
  logic [15:0] fstime_q;      // Fail-safe interval
  logic [7:0]  glitch_q;      // Glitch filter ticks
  logic [2:0]  status_q;      // Sticky events
  logic [2:0]  mask_q;        // Interrupt mask
  fpt_result_t result_q;      // Last result
  logic [3:0]  fs_trip_q;     // Fail-safe forcing
  logic [3:0]  started_q;     // Fans released by start-up
  logic [3:0]  sw_on;         // Channel switch states
  logic [3:0]  tach_lvl;      // Synchronised tach
  logic        aw_hold_q;     // Write address captured
  logic        w_hold_q;      // Write data captured
  logic [7:0]  awaddr_q;      // Held write address
  logic [31:0] wdata_q;       // Held write data
  logic [3:0]  wstrb_q;       // Held strobes
  logic        wr_fire;       // Write performed this cycle
  logic        pwr_wr;        // A power register written
  logic [31:0] rd_word;       // Read mux
  logic        rd_ok;         // Read address mapped
  logic        wr_ok;         // Write address mapped and writable
  logic        ev_result;     // Result event pulse
  logic        ev_fail;       // Fail-safe event pulse
  logic        ev_start;      // Start-up done pulse
  // Step divider for PWM phase
  logic [15:0] step_cnt_q;
  logic        step_en;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      step_cnt_q <= 16'h0000;
    end else begin
      step_cnt_q <= step_en ? 16'h0000 : step_cnt_q + 16'h0001;
    end
  end
  assign step_en = (step_cnt_q == 16'(STEP_CYC - 1));
  // Microsecond tick for tach timing
  logic [5:0] tick_cnt_q;
  logic       tick_en;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tick_cnt_q <= 6'h00;
    end else begin
      tick_cnt_q <= tick_en ? 6'h00 : tick_cnt_q + 6'h01;
    end
  end
  assign tick_en = (tick_cnt_q == 6'(TICK_CYC - 1));
  // Write channel capture, either order
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_hold_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_hold_q <= 1'b0;
      end
    end
  end
  assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;
  // Ready and response flags
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_hold_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_hold_q && !(s_axi_wvalid && s_axi_wready);
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign wr_ok  = (awaddr_q <= ADDR_FANOUT) && (awaddr_q != ADDR_RESULT)
                  && (awaddr_q != ADDR_FANOUT);
  assign pwr_wr = wr_fire && (fpt_word(awaddr_q) < 6'(NFAN)) && wstrb_q[0];
  // Configuration registers; power defaults to full
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NFAN; i++) begin
        pwr_q[i] <= PWR_FULL;
      end
      report_q <= 4'h0;
      fsen_q   <= 4'h0;
      fstime_q <= FAILSAFE_RST;
      glitch_q <= GLITCH_RST;
      mask_q   <= 3'h0;
    end else if (wr_fire && wstrb_q[0]) begin
      if (pwr_wr) begin
        pwr_q[awaddr_q[3:2]] <=
          (wdata_q[7:0] > PWR_FULL) ? PWR_FULL : wdata_q[7:0];
      end
      if (awaddr_q == ADDR_REPORT) report_q <= wdata_q[3:0];
      if (awaddr_q == ADDR_FSEN)   fsen_q   <= wdata_q[3:0];
      if (awaddr_q == ADDR_GLITCH) glitch_q <= wdata_q[7:0];
      if (awaddr_q == ADDR_MASK)   mask_q   <= wdata_q[2:0];
      if (awaddr_q == ADDR_FSTIME) begin
        fstime_q <= {wstrb_q[1] ? wdata_q[15:8] : fstime_q[15:8], wdata_q[7:0]};
      end
    end
  end
  // Sticky status, set wins over write-one-clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      status_q <= 3'h0;
    end else begin
      status_q <= (status_q & ~((wr_fire && wstrb_q[0] && awaddr_q == ADDR_STATUS)
                                ? wdata_q[2:0] : 3'h0))
                  | {ev_start, ev_fail, ev_result};
    end
  end
  // Read channel, one-cycle answer
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    unique case (s_axi_araddr)
      ADDR_PWR0, ADDR_PWR0 + 8'h04, ADDR_PWR0 + 8'h08, ADDR_PWR0 + 8'h0C: begin
        rd_word = {24'h0, pwr_q[s_axi_araddr[3:2]]};
      end
      ADDR_REPORT: rd_word = {28'h0, report_q};
      ADDR_FSEN:   rd_word = {28'h0, fsen_q};
      ADDR_FSTIME: rd_word = {16'h0, fstime_q};
      ADDR_GLITCH: rd_word = {24'h0, glitch_q};
      ADDR_STATUS: rd_word = {29'h0, status_q};
      ADDR_MASK:   rd_word = {29'h0, mask_q};
      ADDR_RESULT: rd_word = {6'h0, result_q};
      ADDR_FANOUT: rd_word = {20'h0, started_q, fs_trip_q, sw_on};
      default:     rd_ok   = 1'b0;
    endcase
  end
  // Read handshake
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // Fail-safe interval timer, restarted by any power write
  logic [15:0] fs_ms_q;
  logic [31:0] fs_div_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fs_ms_q   <= 16'h0000;
      fs_div_q  <= 32'h0000_0000;
      fs_trip_q <= 4'h0;
      ev_fail   <= 1'b0;
    end else begin
      ev_fail <= 1'b0;
      if (pwr_wr) begin
        fs_ms_q   <= 16'h0000;
        fs_div_q  <= 32'h0000_0000;
        fs_trip_q <= 4'h0;
      end else if (fstime_q != 16'h0000 && fs_ms_q < fstime_q) begin
        fs_div_q <= (fs_div_q == MS_CYCLES - 1) ? 32'h0000_0000 : fs_div_q + 32'h1;
        if (fs_div_q == MS_CYCLES - 1) fs_ms_q <= fs_ms_q + 16'h0001;
      end else if (fstime_q != 16'h0000 && (fs_trip_q != fsen_q)) begin
        fs_trip_q <= fsen_q;
        ev_fail   <= |fsen_q;
      end
    end
  end
  // Staggered start: one fan released per gap
  logic [31:0] spin_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      spin_q    <= 32'h0000_0000;
      started_q <= 4'h0;
      ev_start  <= 1'b0;
    end else begin
      ev_start <= 1'b0;
      if (!started_q[3]) begin
        spin_q <= (spin_q == SPIN_CYCLES - 1) ? 32'h0000_0000 : spin_q + 32'h1;
        if (spin_q == SPIN_CYCLES - 1 || started_q == 4'h0) begin
          started_q <= {started_q[2:0], 1'b1};
          ev_start  <= (started_q == 4'h7);
          spin_q    <= 32'h0000_0000;
        end
      end
    end
  end
  // Tach synchronisers, one per fan
  for (genvar g = 0; g < NFAN; g++) begin : g_sync
    fpt_sync u_sync (
      .sys_clk (sys_clk),
      .rst     (rst),
      .pin     (tach_in[g]),
      .level   (tach_lvl[g])
    );
  end
  // Measurement sequencer: rotate fans, 125 ms each
  fpt_mstate_t mst_q;
  logic [1:0]  mfan_q;     // Fan under measurement
  logic [31:0] win_q;      // Window cycle count
  logic [7:0]  gl_cnt_q;   // Glitch filter run
  logic        tach_filt_q; // Filtered tach
  logic [7:0]  cyc_q;      // Qualified edges
  logic [15:0] ticks_q;    // Ticks first to last edge
  logic [15:0] tsince_q;   // Ticks since first edge
  logic        stretch_q;  // Forced on for measurement
  logic        tedge;
  assign tedge = (tach_lvl[mfan_q] != tach_filt_q) && (gl_cnt_q >= glitch_q);
  // Glitch filter on the selected tach
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gl_cnt_q    <= 8'h00;
      tach_filt_q <= 1'b0;
    end else if (tach_lvl[mfan_q] == tach_filt_q) begin
      gl_cnt_q <= 8'h00;
    end else if (tedge) begin
      tach_filt_q <= tach_lvl[mfan_q];
      gl_cnt_q    <= 8'h00;
    end else if (tick_en) begin
      gl_cnt_q <= gl_cnt_q + 8'h01;
    end
  end
  // Sequencer and counters
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mst_q     <= M_IDLE;
      mfan_q    <= 2'h0;
      win_q     <= 32'h0000_0000;
      cyc_q     <= 8'h00;
      ticks_q   <= 16'h0000;
      tsince_q  <= 16'h0000;
      stretch_q <= 1'b0;
      result_q  <= '0;
      ev_result <= 1'b0;
    end else begin
      ev_result <= 1'b0;
      unique case (mst_q)
        M_IDLE: begin
          win_q    <= 32'h0000_0000;
          cyc_q    <= 8'h00;
          ticks_q  <= 16'h0000;
          tsince_q <= 16'h0000;
          stretch_q <= report_q[mfan_q];
          mst_q    <= M_WAIT;
        end
        M_WAIT, M_COUNT: begin
          win_q <= win_q + 32'h1;
          if (tick_en && cyc_q != 8'h00) tsince_q <= tsince_q + 16'h0001;
          if (tedge && tach_filt_q == 1'b0) begin
            cyc_q <= (cyc_q == 8'hFE) ? 8'hFE : cyc_q + 8'h01;
            ticks_q <= tsince_q;
            if (cyc_q >= 8'h01) begin
              stretch_q <= 1'b0;
              mst_q     <= M_COUNT;
            end
          end
          if (win_q == MEAS_CYCLES - 1) begin
            stretch_q <= 1'b0;
            mst_q     <= M_DONE;
          end
        end
        M_DONE: begin
          result_q  <= '{fan: mfan_q, cycles: cyc_q, ticks: ticks_q};
          ev_result <= report_q[mfan_q];
          mfan_q    <= mfan_q + 2'h1;
          mst_q     <= M_IDLE;
        end
      endcase
    end
  end
  // PWM channels with overrides
  for (genvar g = 0; g < NFAN; g++) begin : g_pwm
    fpt_pwm u_pwm (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .step_en  (step_en),
      .duty     (started_q[g] ? pwr_q[g] : 8'h00),
      .force_on (started_q[g] && (fs_trip_q[g] || (stretch_q && mfan_q == 2'(g)))),
      .sw_on    (sw_on[g])
    );
  end

  // Open-drain switch pins and interrupt
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fan_sw_oe <= 4'h0;
      fan_sw_o  <= 4'h0;
      irq       <= 1'b0;
    end else begin
      fan_sw_oe <= sw_on;
      fan_sw_o  <= 4'h0;
      irq       <= |(status_q & mask_q);
    end
  end
endmodule

// [core/fpt_pkg.sv]
// Package for the fan power and tach controller: register map, timing, types.
// Assumes a 40 MHz system clock and a 32-bit AXI4-Lite register bus.
package fpt_pkg;
  localparam int unsigned CLK_HZ         = 40_000_000;  // System clock rate
  localparam int unsigned NFAN           = 4;           // Fan channels
  localparam int unsigned PWM_HZ         = 18;          // Nominal switching rate
  localparam int unsigned PWM_STEPS      = 100;         // Duty steps per period
  localparam int unsigned MEAS_MS        = 125;         // Measurement window
  localparam int unsigned SPIN_MS        = 500;         // Start-up gap
  // Divider ticks: one duty step, rounded down
  localparam int unsigned STEP_CYC       = CLK_HZ / (PWM_HZ * PWM_STEPS);
  // Measurement window in cycles
  localparam int unsigned MEAS_CYC       = (CLK_HZ / 1000) * MEAS_MS;
  // Start-up gap in cycles
  localparam int unsigned SPIN_CYC       = (CLK_HZ / 1000) * SPIN_MS;
  // Tach timer tick rate: one tick per microsecond
  localparam int unsigned TICK_CYC       = CLK_HZ / 1_000_000;
  localparam logic [7:0]  PWR_FULL       = 8'h64;       // 100 percent
  localparam logic [7:0]  GLITCH_RST     = 8'h01;       // Filter delay, ticks
  localparam logic [15:0] FAILSAFE_RST   = 16'h0000;    // Fail-safe interval, ms
  // Register byte offsets
  localparam logic [7:0] ADDR_PWR0     = 8'h00;  // Fan power 0..3 at +4 each
  localparam logic [7:0] ADDR_REPORT   = 8'h10;  // Report enable bits [3:0]
  localparam logic [7:0] ADDR_FSEN     = 8'h14;  // Fail-safe enable bits [3:0]
  localparam logic [7:0] ADDR_FSTIME   = 8'h18;  // Fail-safe interval ms [15:0]
  localparam logic [7:0] ADDR_GLITCH   = 8'h1C;  // Glitch filter ticks [7:0]
  localparam logic [7:0] ADDR_STATUS   = 8'h20;  // Sticky events, W1C
  localparam logic [7:0] ADDR_MASK     = 8'h24;  // Interrupt mask
  localparam logic [7:0] ADDR_RESULT   = 8'h28;  // Last speed result
  localparam logic [7:0] ADDR_FANOUT   = 8'h2C;  // Live switch and fail-safe state
  // Status bit positions
  localparam int unsigned ST_RESULT   = 0;  // New speed result
  localparam int unsigned ST_FAILSAFE = 1;  // Fail-safe fired
  localparam int unsigned ST_STARTED  = 2;  // Start-up sequence done
  localparam logic [1:0] RESP_OKAY   = 2'b00;  // AXI okay
  localparam logic [1:0] RESP_SLVERR = 2'b10;  // AXI unmapped or read-only write

  // One speed result: fan index, tach cycles, 16-bit timer ticks
  typedef struct packed {
    logic [1:0]  fan;
    logic [7:0]  cycles;
    logic [15:0] ticks;
  } fpt_result_t;

  // Tach measurement sequencer states, Gray along IDLE-WAIT-COUNT-DONE; WAIT to DONE flips both bits
  typedef enum logic [1:0] {
    M_IDLE  = 2'b00,
    M_WAIT  = 2'b01,
    M_COUNT = 2'b11,
    M_DONE  = 2'b10
  } fpt_mstate_t;

  // Byte address to word index
  function automatic logic [5:0] fpt_word(input logic [7:0] a);
    return a[7:2];
  endfunction
endpackage

// [core/fpt_pwm.sv]
// One fan channel: duty-step PWM with stretch and force overrides.
// Assumes a step enable pulse from the top-level divider.
module fpt_pwm
  import fpt_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       step_en,
  input  wire logic [7:0] duty,
  input  wire logic       force_on,
  output logic            sw_on
);
  logic [6:0] phase_q;  // Step within the period

  // Step counter, 100 steps per period
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phase_q <= 7'h00;
    end else if (step_en) begin
      phase_q <= (phase_q == 7'(PWM_STEPS - 1)) ? 7'h00 : phase_q + 7'h01;
    end
  end

  // Switch closed while phase below duty or overridden
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sw_on <= 1'b0;
    end else begin
      sw_on <= force_on || ({1'b0, phase_q} < duty);
    end
  end
endmodule

// [core/fpt_sync.sv]
// Three-stage synchroniser with agreement filter for one pin input.
// Assumes the pin is asynchronous to sys_clk.
module fpt_sync (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic pin,
  output logic      level
);
  logic s1_q;  // First stage, read by s2 only
  logic s2_q;  // Second stage
  logic s3_q;  // Third stage

  // Shift chain; level follows once stages two and three agree
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s1_q  <= 1'b0;
      s2_q  <= 1'b0;
      s3_q  <= 1'b0;
      level <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level <= s3_q;
      end
    end
  end
endmodule

// [tb/fpt_fan_model.sv]
// Four three-pin fans: tach toggles while the fan is powered and not stalled.
// Assumes the switch enable powers a fan; tach lines have pull-ups.
module fpt_fan_model #(
  parameter realtime HALF_NS = 4013.0  // Tach half period
) (
  input  wire logic [3:0] fan_sw_oe,
  input  wire logic       stall,
  output logic      [3:0] tach
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] run;  // Fans spinning now
  assign run = fan_sw_oe & {4{~stall}};
  // Spinning fans toggle; idle ones rest at the pull-up level
  initial begin
    tach = 4'hF;
    forever begin
      #(HALF_NS);
      tach = (tach ^ run) | ~run;
    end
  end
endmodule

// [tb/fpt_top_checker.sv]
// Port checks for the fan controller.
// Assumes it is bound onto fpt_top with its start-up gap.
module fpt_top_checker #(
  parameter int unsigned SPIN_CYCLES = 100  // Start-up gap
) (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [3:0]  fan_sw_oe,
  input wire logic [3:0]  fan_sw_o,
  input wire logic        irq
);
  int unsigned age_q;  // Cycles since reset release
  // Saturating age counter
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      age_q <= 0;
    end else if (age_q < 4 * SPIN_CYCLES) begin
      age_q <= age_q + 1;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  drain_low_a: assert property (fan_sw_o == 4'h0)
    else $error("switch data not low");
  reset_quiet_a: assert property (disable iff (1'b0) rst |-> fan_sw_oe == 4'h0 && !irq)
    else $error("outputs active in reset");
  spin_one_a: assert property (age_q < SPIN_CYCLES - 8 |-> $countones(fan_sw_oe) <= 1)
    else $error("two fans in first gap");
  spin_two_a: assert property (age_q < 2 * SPIN_CYCLES - 8 |-> $countones(fan_sw_oe) <= 2)
    else $error("three fans in second gap");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read answer dropped");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  aw_refuse_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("address taken twice");
endmodule

bind fpt_top fpt_top_checker #(.SPIN_CYCLES(SPIN_CYCLES)) u_chk (.sys_clk, .rst,
  .s_axi_awvalid, .s_axi_awready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .fan_sw_oe, .fan_sw_o, .irq);

// [tb/fpt_top_bench.sv]
// Bench for the fan controller: start-up, power, stretch, fail-safe.
// Assumes the fan model answers the switches with tach toggles.
module fpt_top_bench import fpt_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MEAS = 2000;  // Short window
  localparam int SPIN = 100;   // Short start-up gap
  logic        sys_clk, rst, stall, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb, tach_in, fan_sw_oe, fan_sw_o;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  int          miscompares, tests_run, n, clk_cnt;
  fpt_top #(.MEAS_CYCLES(MEAS), .SPIN_CYCLES(SPIN), .MS_CYCLES(40)) u_dut (.sys_clk,
    .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .tach_in, .fan_sw_oe, .fan_sw_o, .irq);
  fpt_fan_model u_fans (.fan_sw_oe, .stall, .tach(tach_in));
  // 40 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Free-running cycle count for interval checks
  always @(posedge sys_clk) clk_cnt <= clk_cnt + 1;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic tmo(input string m);
    miscompares++;
    $display("[FAIL] %0t timeout %s", $time, m);
    wrap_up();
  endtask
  // Bus write: address and data together, answer taken when offered
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // Each channel drops valid at its own taking edge; answer taken when seen
    for (k = 0; k < 50; k++) begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (k == 50) tmo("write");
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // Bus read
  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    // Address dropped when taken; data taken at the edge rvalid is seen
    for (k = 0; k < 50; k++) begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (k == 50) tmo("read");
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Bounded wait for one switch to reach a level; n holds the cycles
  task automatic wt(input int b, input logic v, input int lim);
    for (n = 0; n < lim && fan_sw_oe[b] !== v; n++) @(posedge sys_clk);
    if (n == lim) tmo("fan switch");
  endtask
  task automatic sc_startup();
    repeat (20) @(posedge sys_clk);
    chk(fan_sw_oe, 4'h1, "first fan alone");
    repeat (SPIN) @(posedge sys_clk);
    chk(fan_sw_oe, 4'h3, "second fan");
    repeat (2 * SPIN) @(posedge sys_clk);
    chk(fan_sw_oe, 4'hF, "all fans full");
    rdr(ADDR_PWR0 + 8'h0C, rd, rsp);
    chk(rd, 32'h64, "power reset");
    rdr(ADDR_STATUS, rd, rsp);
    chk(rd[ST_STARTED], 1'b1, "start-up done");
    rdr(8'h30, rd, rsp);
    chk(rsp, RESP_SLVERR, "unmapped");
    wr(ADDR_RESULT, 32'h0, rsp);
    chk(rsp, RESP_SLVERR, "result read-only");
  endtask
  task automatic sc_power();
    for (int i = 0; i < 4; i++) wr(ADDR_PWR0 + 8'(4 * i), 32'h0, rsp);
    for (int i = 0; i < 4; i++) wt(i, 1'b0, STEP_CYC + 50);
    chk(fan_sw_oe, 4'h0, "zero power off");
    chk(fan_sw_o, 4'h0, "drain data low");
    wr(ADDR_PWR0, 32'hC8, rsp);
    chk(rsp, RESP_OKAY, "power write");
    wt(0, 1'b1, STEP_CYC + 50);
    chk(fan_sw_oe, 4'h1, "clamped full on");
  endtask
  task automatic sc_measure();
    int t0;
    wr(ADDR_REPORT, 32'h4, rsp);
    wt(2, 1'b1, 5 * MEAS);
    t0 = clk_cnt;
    chk(fan_sw_oe, 4'h5, "reported fan forced");
    wt(2, 1'b0, MEAS);
    chk(n < MEAS / 2, 1'b1, "released after edges");
    // Let the window of fan 2 close so its result is the latest one
    repeat (MEAS) @(posedge sys_clk);
    rdr(ADDR_RESULT, rd, rsp);
    chk(rd[25:24], 2'h2, "result fan");
    chk(rd[23:16] != 8'h0, 1'b1, "tach cycles");
    chk(rd[15:0] != 16'h0, 1'b1, "timer ticks");
    wt(2, 1'b1, 5 * MEAS);
    chk((clk_cnt - t0) inside {[4 * MEAS - 20 : 4 * MEAS + 20]}, 1'b1, "rotation");
    stall <= 1'b1;
    wr(ADDR_MASK, 32'h1, rsp);
    repeat (3) @(posedge sys_clk);
    chk(irq, 1'b1, "result irq");
    wr(ADDR_STATUS, 32'h7, rsp);
    repeat (3) @(posedge sys_clk);
    chk(irq, 1'b0, "irq cleared");
    wt(2, 1'b0, 2 * MEAS);
    chk(n inside {[MEAS - 100 : MEAS]}, 1'b1, "stretch limit");
    stall <= 1'b0;
    wr(ADDR_MASK, 32'h0, rsp);
    wr(ADDR_REPORT, 32'h0, rsp);
  endtask
  task automatic sc_failsafe();
    wr(ADDR_FSEN, 32'h2, rsp);
    wr(ADDR_FSTIME, 32'h3, rsp);
    repeat (6) begin
      repeat (60) @(posedge sys_clk);
      chk(fan_sw_oe[1], 1'b0, "refresh holds");
      wr(ADDR_PWR0 + 8'h08, 32'h0, rsp);
    end
    wt(1, 1'b1, 200);
    chk(fan_sw_oe[3:1], 3'h1, "only enabled fan");
    rdr(ADDR_STATUS, rd, rsp);
    chk(rd[ST_FAILSAFE], 1'b1, "fail-safe event");
    wr(ADDR_PWR0 + 8'h04, 32'h0, rsp);
    wr(ADDR_FSTIME, 32'h0, rsp);
    wt(1, 1'b0, STEP_CYC + 50);
    chk(fan_sw_oe[1], 1'b0, "write clears force");
    // Leave fans 1 to 3 at a safe minimum duty
    for (int i = 1; i < 4; i++) wr(ADDR_PWR0 + 8'(4 * i), 32'h28, rsp);
  endtask
  // Main sequence
  initial begin
    {rst, s_axi_wstrb} = 5'h1F;
    {stall, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    miscompares = 0;
    tests_run = 0;
    repeat (5) @(posedge sys_clk);
    chk(fan_sw_oe, 4'h0, "quiet in reset");
    rst <= 1'b0;
    sc_startup();
    sc_power();
    sc_measure();
    sc_failsafe();
    wrap_up();
  end
endmodule
